/* hw/lbp_defs.svh */
// Constants of the LED intensity and blink PWM block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef LBP_DEFS_SVH
`define LBP_DEFS_SVH

`define LBP_ADDR_W        8
`define LBP_DATA_W        32
`define LBP_NUM_OUT       9
`define LBP_NUM_LOW       8
`define LBP_LVL_W         4

`define LBP_IDX_CTRL      6'h00
`define LBP_IDX_PH0       6'h01
`define LBP_IDX_PH1       6'h02
`define LBP_IDX_NINTH_PH  6'h03
`define LBP_IDX_STATUS    6'h04
`define LBP_IDX_INTENS    6'h0E
`define LBP_IDX_OUT_FIRST 6'h10
`define LBP_IDX_OUT_LAST  6'h13

`define LBP_CTRL_BLINK    0
`define LBP_CTRL_PHASE    1
`define LBP_CTRL_GLOBAL   2
`define LBP_MASTER_HI     7
`define LBP_MASTER_LO     4
`define LBP_NINTH_HI      3
`define LBP_NINTH_LO      0
`define LBP_ST_RUN        9
`define LBP_ST_PHASE      10
`define LBP_ST_SLOT_LO    12
`define LBP_ST_SLOT_HI    15

`define LBP_RST_CTRL      3'h0
`define LBP_RST_INTENS    8'h00
`define LBP_RST_BYTE      8'h00
`define LBP_RST_OUT_LVL   32'h0000_0000

`define LBP_LVL_STATIC    4'hF
`define LBP_LVL_ZERO      4'h0
`define LBP_SLOT_LAST     4'hF
`define LBP_SUB_LAST      4'hE
`define LBP_DIV_W         3
`define LBP_DIV_LAST      3'h7
`define LBP_ZERO_W32      32'h0000_0000

`endif

/* hw/lbp_pkg.sv */
// Types shared by the LED intensity and blink PWM block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "lbp_defs.svh"

package lbp_pkg;

   typedef struct packed {
      logic                     psel;
      logic                     penable;
      logic                     pwrite;
      logic [`LBP_ADDR_W-1:0]   paddr;
      logic [`LBP_DATA_W-1:0]   pwdata;
   } lbp_apb_req_t;

   typedef struct packed {
      logic [`LBP_DATA_W-1:0]   prdata;
      logic                     pready;
      logic                     pslverr;
   } lbp_apb_rsp_t;

   typedef struct packed {
      logic [2:0]               ctrl;
      logic [7:0]               intens;
      logic [31:0]              out_lvl;
      logic [7:0]               ph0;
      logic [7:0]               ph1;
      logic [1:0]               ninth_ph;
      logic [`LBP_DIV_W-1:0]    div;
      logic [3:0]               sub;
      logic [3:0]               slot;
      logic                     phase_eff;
      logic [`LBP_NUM_OUT-1:0]  oe;
      logic [`LBP_NUM_OUT-1:0]  pin_s1;
      logic [`LBP_NUM_OUT-1:0]  pin_s2;
      logic [`LBP_DATA_W-1:0]   rdata;
      logic                     err;
   } lbp_state_t;

endpackage

`default_nettype wire

/* hw/lbp_top.sv */
// LED intensity and blink PWM logic for nine open-drain outputs, with APB registers.
// Assumes one 125 MHz clock, synchronous active-high reset, APB master on the same clock.
//
// The APB slave port was decided locally.
`default_nettype none
`include "lbp_defs.svh"

module lbp_top (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   input  wire lbp_pkg::lbp_apb_req_t    apb_req,
   output var  lbp_pkg::lbp_apb_rsp_t    apb_rsp,
   input  wire logic [`LBP_NUM_OUT-1:0]  led_i,
   output logic      [`LBP_NUM_OUT-1:0]  led_o,
   output logic      [`LBP_NUM_OUT-1:0]  led_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and PWM level functions.

   function automatic logic addr_hit(input logic [`LBP_ADDR_W-1:0] a,
                                     input logic [5:0]             idx);
      addr_hit = (a[1:0] == 2'h0) && (a[`LBP_ADDR_W-1:2] == idx);
   endfunction

   function automatic logic addr_is_out(input logic [`LBP_ADDR_W-1:0] a);
      addr_is_out = (a[1:0] == 2'h0) && (a[`LBP_ADDR_W-1:2] >= `LBP_IDX_OUT_FIRST)
                    && (a[`LBP_ADDR_W-1:2] <= `LBP_IDX_OUT_LAST);
   endfunction

   function automatic logic pwm_low(input logic [3:0] lvl,
                                    input logic       inv,
                                    input logic [3:0] slot,
                                    input logic [3:0] sub,
                                    input logic [3:0] mst);
      logic on;
      on = 1'b0;
      if (mst == `LBP_LVL_ZERO) begin
         pwm_low = 1'b0;
      end else if (lvl == `LBP_LVL_STATIC) begin
         pwm_low = !inv;
      end else begin
         on      = inv ? (slot > lvl) : (slot <= lvl);
         pwm_low = on && (sub < mst);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State.

   lbp_pkg::lbp_state_t             r_reg;
   lbp_pkg::lbp_state_t             r_next;
   logic [`LBP_NUM_OUT-1:0]         low_vec;
   logic [3:0]                      master_lvl;
   logic [3:0]                      ninth_lvl;
   logic                            tick;
   logic                            cyc_end;
   logic                            wr_en;
   logic                            rd_setup;
   logic [1:0]                      out_pair;

   assign master_lvl = r_reg.intens[`LBP_MASTER_HI:`LBP_MASTER_LO];
   assign ninth_lvl  = r_reg.intens[`LBP_NINTH_HI:`LBP_NINTH_LO];
   assign tick       = (master_lvl != `LBP_LVL_ZERO) && (r_reg.div == `LBP_DIV_LAST);
   assign cyc_end    = tick && (r_reg.sub == `LBP_SUB_LAST)
                       && (r_reg.slot == `LBP_SLOT_LAST);
   assign wr_en      = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_setup   = apb_req.psel && !apb_req.penable;
   assign out_pair   = apb_req.paddr[3:2];

   ////////////////////////////////////////////////////////////////////////////
   // Per-output drive from the shared counter.

   genvar gi;
   generate
      for (gi = 0; gi < `LBP_NUM_LOW; gi++) begin : g_low
         logic [3:0] lvl;
         logic       bit_sel;
         assign lvl     = r_reg.ctrl[`LBP_CTRL_GLOBAL] ? ninth_lvl
                                                       : r_reg.out_lvl[gi*4 +: 4];
         assign bit_sel = (r_reg.ctrl[`LBP_CTRL_BLINK] && r_reg.phase_eff)
                          ? r_reg.ph1[gi] : r_reg.ph0[gi];
         assign low_vec[gi] = pwm_low(lvl, bit_sel, r_reg.slot, r_reg.sub, master_lvl);
      end
   endgenerate

   logic ninth_bit;
   assign ninth_bit = (r_reg.ctrl[`LBP_CTRL_BLINK] && r_reg.phase_eff)
                      ? r_reg.ninth_ph[1] : r_reg.ninth_ph[0];
   assign low_vec[`LBP_NUM_LOW] = pwm_low(ninth_lvl, ninth_bit, r_reg.slot,
                                          r_reg.sub, master_lvl);

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      r_next        = r_reg;
      r_next.pin_s1 = led_i;
      r_next.pin_s2 = r_reg.pin_s1;
      r_next.oe     = low_vec;
      if (master_lvl == `LBP_LVL_ZERO) begin
         r_next.div = r_reg.div;
      end else begin
         r_next.div = (r_reg.div == `LBP_DIV_LAST) ? '0 : r_reg.div + 1'b1;
      end
      if (tick) begin
         r_next.sub = (r_reg.sub == `LBP_SUB_LAST) ? '0 : r_reg.sub + 1'b1;
         if (r_reg.sub == `LBP_SUB_LAST) begin
            r_next.slot = r_reg.slot + 1'b1;
         end
      end
      if (cyc_end) begin
         r_next.phase_eff = r_reg.ctrl[`LBP_CTRL_PHASE];
      end
      if (rd_setup) begin
         r_next.err   = 1'b0;
         r_next.rdata = `LBP_ZERO_W32;
         if (addr_hit(apb_req.paddr, `LBP_IDX_CTRL)) begin
            r_next.rdata[2:0] = r_reg.ctrl;
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_PH0)) begin
            r_next.rdata[7:0] = r_reg.ph0;
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_PH1)) begin
            r_next.rdata[7:0] = r_reg.ph1;
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_NINTH_PH)) begin
            r_next.rdata[1:0] = r_reg.ninth_ph;
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_STATUS)) begin
            r_next.rdata[`LBP_NUM_OUT-1:0]                 = r_reg.pin_s2;
            r_next.rdata[`LBP_ST_RUN]                      = master_lvl != `LBP_LVL_ZERO;
            r_next.rdata[`LBP_ST_PHASE]                    = r_reg.phase_eff;
            r_next.rdata[`LBP_ST_SLOT_HI:`LBP_ST_SLOT_LO]  = r_reg.slot;
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_INTENS)) begin
            r_next.rdata[7:0] = r_reg.intens;
         end else if (addr_is_out(apb_req.paddr)) begin
            r_next.rdata[7:0] = r_reg.out_lvl[out_pair*8 +: 8];
         end else begin
            r_next.err = 1'b1;
         end
      end
      if (wr_en) begin
         if (addr_hit(apb_req.paddr, `LBP_IDX_CTRL)) begin
            r_next.ctrl = apb_req.pwdata[2:0];
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_PH0)) begin
            r_next.ph0 = apb_req.pwdata[7:0];
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_PH1)) begin
            r_next.ph1 = apb_req.pwdata[7:0];
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_NINTH_PH)) begin
            r_next.ninth_ph = apb_req.pwdata[1:0];
         end else if (addr_hit(apb_req.paddr, `LBP_IDX_INTENS)) begin
            r_next.intens = apb_req.pwdata[7:0];
         end else if (addr_is_out(apb_req.paddr)) begin
            r_next.out_lvl[out_pair*8 +: 8] = apb_req.pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r_reg           <= '0;
         r_reg.ctrl      <= `LBP_RST_CTRL;
         r_reg.intens    <= `LBP_RST_INTENS;
         r_reg.out_lvl   <= `LBP_RST_OUT_LVL;
         r_reg.ph0       <= `LBP_RST_BYTE;
         r_reg.ph1       <= `LBP_RST_BYTE;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign led_o           = '0;
   assign led_oe          = r_reg.oe;
   assign apb_rsp = '{prdata:  r_reg.rdata,
                      pready:  apb_req.psel && apb_req.penable,
                      pslverr: r_reg.err && apb_req.psel && apb_req.penable && !apb_req.pwrite};

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_master_zero_static: assert property ((master_lvl == 4'h0) |=> (led_oe == 9'h000))
      else $error("outputs modulated while master level is zero");

   a_osc_stopped: assert property ((master_lvl == 4'h0) ##1 (master_lvl == 4'h0)
                                   |-> $stable(r_reg.div) && $stable(r_reg.slot))
      else $error("oscillator counters moved while master level is zero");

   a_master_gate: assert property ((master_lvl != 4'h0) && (r_reg.sub >= master_lvl)
                                   && (ninth_lvl != 4'hF) |=> !led_oe[8])
      else $error("ninth output sank outside the master fraction");

   a_ninth_duty: assert property ((master_lvl == 4'hF) && !ninth_bit && (ninth_lvl != 4'hF)
                                  |=> (led_oe[8] == ($past(r_reg.slot) <= $past(ninth_lvl))))
      else $error("ninth output low time differs from level plus one");

   a_ninth_invert: assert property ((master_lvl == 4'hF) && ninth_bit && (ninth_lvl != 4'hF)
                                    |=> (led_oe[8] == ($past(r_reg.slot) > $past(ninth_lvl))))
      else $error("inverted pattern wrong on ninth output");

   a_static_low: assert property ((master_lvl != 4'h0) && (ninth_lvl == 4'hF) && !ninth_bit
                                  |=> led_oe[8])
      else $error("static level did not hold the ninth output low");

   a_static_hiz: assert property ((master_lvl != 4'h0) && (ninth_lvl == 4'hF) && ninth_bit
                                  |=> !led_oe[8])
      else $error("static level did not release the ninth output");

   a_half_level: assert property ((master_lvl == 4'hF) && !r_reg.ctrl[`LBP_CTRL_GLOBAL]
                                  && (r_reg.out_lvl[3:0] == 4'h7) && (r_reg.slot == 4'h8)
                                  |=> (led_oe[0] == $past(g_low[0].bit_sel)))
      else $error("level seven gave the wrong drive in the second half");

   a_phase_boundary: assert property (!$stable(r_reg.phase_eff) |-> $past(cyc_end))
      else $error("blink phase changed inside a PWM cycle");

   a_read_back: assert property (rd_setup && !apb_req.pwrite
                                 && addr_hit(apb_req.paddr, `LBP_IDX_INTENS)
                                 |=> (apb_rsp.prdata[7:0] == $past(r_reg.intens)))
      else $error("intensity register read returned wrong fields");

   a_write_fields: assert property (wr_en && addr_hit(apb_req.paddr, `LBP_IDX_INTENS)
                                    |=> (master_lvl == $past(apb_req.pwdata[7:4]))
                                        && (ninth_lvl == $past(apb_req.pwdata[3:0])))
      else $error("intensity register write stored wrong fields");

endmodule

`default_nettype wire

/* testbench/lbp_apb_host.sv */
// APB master model that programs the LED intensity block.
// Assumes it shares the block's clock and starts after the bench releases reset.
`default_nettype none

module lbp_apb_host (
   input  wire logic                  clk_sys,
   input  wire lbp_pkg::lbp_apb_rsp_t apb_rsp,
   output var  lbp_pkg::lbp_apb_req_t apb_req,
   output var  logic                  stall
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      apb_req = '0;
      stall = 1'b0;
   end

   // Setup cycle, then access held until pready is sampled high or 16 clocks have passed.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_sys);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= w;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 16);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      stall <= (apb_rsp.pready !== 1'b1);
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      apb_req.paddr <= ~a;
      apb_req.pwdata <= ~d;
   endtask
endmodule

`default_nettype wire

/* testbench/tb_led_blink_pwm_intensity.sv */
// Self-checking bench for the LED intensity and blink PWM block.
// Assumes the package, the block and the APB master model are compiled first.
`default_nettype none

module tb_led_blink_pwm_intensity;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  clk_sys;
   logic                  reset;
   lbp_pkg::lbp_apb_req_t apb_req;
   lbp_pkg::lbp_apb_rsp_t apb_rsp;
   logic [8:0]            led_oe;
   logic [8:0]            led_o;
   logic                  stall;
   int                    bad_count;
   int                    checks;
   logic [31:0]           q;
   logic                  e;

   lbp_top i_dut (
      .clk_sys (clk_sys),
      .reset   (reset),
      .apb_req (apb_req),
      .apb_rsp (apb_rsp),
      .led_i   (~led_oe),
      .led_o   (led_o),
      .led_oe  (led_oe)
   );

   lbp_apb_host u_host (
      .clk_sys (clk_sys),
      .apb_rsp (apb_rsp),
      .apb_req (apb_req),
      .stall   (stall)
   );

   always #4 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(w, a, d, q, e);
      @(negedge clk_sys);
      if (stall !== 1'b0) begin
         bad_count++;
         results();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Cases: master, ninth level, output level, phase bits, ninth phase bits, control.
   logic [3:0]  tm [11] = '{4'h0, 4'hF, 4'hF, 4'hF, 4'hF, 4'h5, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
   logic [3:0]  tl [11] = '{4'hF, 4'h0, 4'h7, 4'hF, 4'hF, 4'h3, 4'h3, 4'hA, 4'hE, 4'h2, 4'h1};
   logic [3:0]  tv [11] = '{4'hF, 4'h0, 4'h7, 4'hF, 4'hF, 4'h3, 4'h3, 4'hA, 4'hE, 4'hC, 4'hB};
   logic        t0 [11] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
   logic        t1 [11] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   logic [1:0]  tn [11] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h1, 2'h0};
   logic [2:0]  tc [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h1, 3'h4, 3'h3};
   logic [7:0]  ra [7]  = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h38, 8'h40};
   logic [31:0] rx [7]  = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                            32'h0000_01FF, 32'h0000_0000, 32'h0000_0000};

   // Clocks per PWM cycle that an output sinks, from master, level and pattern bit.
   function automatic int exp_low(input logic [3:0] m, input logic [3:0] lvl, input logic s);
      if (m == 4'h0)
         return 0;
      if (lvl == 4'hF)
         return s ? 0 : 1920;
      return (s ? 15 - lvl : lvl + 1) * m * 8;
   endfunction

   initial begin
      int cnt [9];
      int nx;
      int ex;
      logic s;
      logic [3:0] lv;
      clk_sys = 1'b0;
      reset = 1'b1;
      bad_count = 0;
      checks = 0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("oe_reset", {23'h0, led_oe}, 32'h0000_0000);
      chk("o_low", {23'h0, led_o}, 32'h0000_0000);
      foreach (ra[i]) begin
         acc(1'b0, ra[i], 32'h0000_0000);
         chk("reg_reset", q, rx[i]);
      end
      acc(1'b1, 8'h38, 32'hFFFF_FFA5);
      acc(1'b0, 8'h38, 32'h0000_0000);
      chk("intens_rb", q, 32'h0000_00A5);
      acc(1'b1, 8'hFC, 32'hFFFF_FFFF);
      chk("unmapped_wr", {31'h0, e}, 32'h0000_0000);
      acc(1'b0, 8'hFC, 32'h0000_0000);
      chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
      chk("unmapped_rd", q, 32'h0000_0000);
      for (int i = 0; i < 11; i++) begin
         acc(1'b1, 8'h38, {24'h0, tm[i], tl[i]});
         for (int k = 0; k < 4; k++) begin
            acc(1'b1, 8'h40 + 8'(4 * k), {24'h0, tv[i], tv[i]});
         end
         acc(1'b1, 8'h04, {24'h0, {8{t0[i]}}});
         acc(1'b1, 8'h08, {24'h0, {8{t1[i]}}});
         acc(1'b1, 8'h0C, {30'h0, tn[i]});
         acc(1'b1, 8'h00, {29'h0, tc[i]});
         repeat (2000) @(posedge clk_sys);
         acc(1'b0, 8'h10, 32'h0000_0000);
         chk("osc_run", {31'h0, q[9]}, {31'h0, tm[i] != 4'h0});
         chk("phase_eff", {31'h0, q[10]}, {31'h0, tc[i][1]});
         cnt = '{default: 0};
         nx = 0;
         repeat (1920) begin
            @(negedge clk_sys);
            nx += $isunknown(led_oe);
            for (int j = 0; j < 9; j++) begin
               cnt[j] += (led_oe[j] === 1'b1);
            end
         end
         chk("oe_known", nx, 0);
         s  = (tc[i][0] && tc[i][1]) ? t1[i] : t0[i];
         lv = tc[i][2] ? tl[i] : tv[i];
         ex = exp_low(tm[i], lv, s);
         for (int j = 0; j < 8; j++) begin
            chk($sformatf("out%0d_low", j), cnt[j], ex);
         end
         s  = (tc[i][0] && tc[i][1]) ? tn[i][1] : tn[i][0];
         ex = exp_low(tm[i], tl[i], s);
         chk("ninth_low", cnt[8], ex);
      end
      results();
   end
endmodule

`default_nettype wire
